//--- core/cpu_regs.v
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Operation
// - accumulator, 4 bits, takes ALU results; 4-bit second register is written only from the bus
// - bank select chooses bank 0 or 1 for the banked RAM range
// - RAM below and above the banked range ignores bank select
// - bank select sits at a fixed RAM address, read and written there
// - indirect address from 2-bit page and two 4-bit index registers
// - low index also selects one line of the bit port
// - two 4-bit auxiliary registers pair with high and low index
// - carry from overflow, set, clear, rotate left and right
// - carry pushed on interrupt, popped only by interrupt return
// - status pushed on interrupt, popped only by interrupt return
// - status from overflow, non-zero, bit test; conditions branches
// - status holds until an operation defines a new one
// - status becomes one after every branch or call
// - program counter is a 14-bit binary counter
// - 10-bit stack pointer to next free slot, sixteen levels
// - stack pointer down four per push, up four per pop
// - stack pointer to top on reset and on clearing stack bit
// - reset input high resets the core
// - reset sets pc, status, stack, bank, interrupt bits
// - reset sets port outputs to one, directions to zero
// - reset clears mode, timer, serial, display and flag registers
// - data registers and carry are left undefined by reset
// - RAM contents are kept through reset
// - top 64 digits are the stack, four digits per level
// - stack bit only triggers stack pointer reload
`include "cpu_regs_map.vh"

module cpu_regs (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // avalon-mm slave
  input  wire [10:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  // core state
  output reg  [13:0] pc_q,
  output reg  [9:0]  sp_q,
  output reg  [9:0]  ind_addr_q,
  output reg  [15:0] port_line_q,
  output reg  [3:0]  port_out_q,
  output reg  [3:0]  port_dir_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [3:0]  mem [0:`RAM_DEPTH-1];
  reg [3:0]  acc_q;
  reg [3:0]  breg_q;
  reg [1:0]  page_q;
  reg [3:0]  hidx_q;
  reg [3:0]  lidx_q;
  reg [3:0]  haux_q;
  reg [3:0]  laux_q;
  reg        carry_flag;
  reg        condition_flag;
  reg [3:0]  bank_q;
  reg        global_irq_enable;
  reg [5:0]  irq_req_q;
  reg [5:0]  irq_mask_bit;
  reg        low_speed_flag;
  reg        watchdog_flag;
  reg        direct_transfer_flag;
  reg [7:0]  periph_q [0:15];
  reg        rst_meta_q;
  reg        rst_sync_q;
  integer    i;

  // ----------------------------------------------------------------
  // reset release: asserts at once, lets go two edges after the pin
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= 1'b1;
    end else begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // address helpers
  // ----------------------------------------------------------------
  // maps a RAM index to its physical digit, folding in the bank
  function [10:0] phys;
    input [9:0] a;
    input [3:0] bank;
    begin
      if (a >= `BANK_LO && a <= `BANK_HI && bank[0]) begin
        phys = `BANK1_BASE + {1'b0, a - `BANK_LO};
      end else begin
        phys = {1'b0, a};
      end
    end
  endfunction

  // stack digit at a given distance above or below the pointer
  function [9:0] stk;
    input [9:0] base;
    input [2:0] ofs;
    input       up;
    begin
      if (up) begin
        stk = base + {7'h00, ofs};
      end else begin
        stk = base - {7'h00, ofs};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  wire        req    = (read | write) & waitrequest;
  wire        wr     = write & waitrequest;
  wire        op_go  = wr && address == `IDX_OP;
  wire [3:0]  op     = writedata[3:0];
  wire [13:0] target = writedata[17:4];
  wire [3:0]  wd4    = writedata[3:0];
  wire        ram_wr = wr && address <= `IDX_RAM_LAST;
  wire [9:0]  ind    = {page_q, hidx_q, lidx_q};
  wire [3:0]  ind_m  = mem[phys(ind, bank_q)];
  wire [4:0]  sum    = {1'b0, acc_q} + {1'b0, ind_m};
  wire        push   = op_go && (op == `OP_INT_ENTRY ||
                       (op == `OP_CALL && condition_flag));
  wire        pop    = op_go && (op == `OP_RET || op == `OP_RET_INT);
  // a level holds pc low at its top digit, flags three digits below
  wire [3:0]  pd0    = mem[stk(sp_q, 3'h4, 1'b1)];
  wire [3:0]  pd1    = mem[stk(sp_q, 3'h3, 1'b1)];
  wire [3:0]  pd2    = mem[stk(sp_q, 3'h2, 1'b1)];
  wire [3:0]  pd3    = mem[stk(sp_q, 3'h1, 1'b1)];
  wire [13:0] ret_pc = {pd3[1:0], pd2, pd1, pd0};
  // control bits and bank select sit in the map but not in RAM
  wire        sfr    = address == `IDX_BANK_SEL ||
                       address <= `IDX_IRQ3 ||
                       address == `IDX_FLAGS;

  // ----------------------------------------------------------------
  // data registers: no reset, software initialises them
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (op_go) begin
      case (op)
        `OP_ADD: begin
          acc_q      <= sum[3:0];
          carry_flag <= sum[4];
        end
        `OP_SET_CARRY: carry_flag <= 1'b1;
        `OP_CLR_CARRY: carry_flag <= 1'b0;
        `OP_ROT_LEFT: begin
          {carry_flag, acc_q} <= {acc_q, carry_flag};
        end
        `OP_ROT_RIGHT: begin
          {acc_q, carry_flag} <= {carry_flag, acc_q};
        end
        `OP_RET_INT: carry_flag <= pd3[2];
        `OP_XCHG_HIGH: begin
          hidx_q <= haux_q;
          haux_q <= hidx_q;
        end
        `OP_XCHG_LOW: begin
          lidx_q <= laux_q;
          laux_q <= lidx_q;
        end
        default: begin
        end
      endcase
    end else if (wr) begin
      case (address)
        `IDX_ACC:  acc_q  <= wd4;
        `IDX_BREG: breg_q <= wd4;
        `IDX_PAGE: page_q <= writedata[1:0];
        `IDX_HIDX: hidx_q <= wd4;
        `IDX_LIDX: lidx_q <= wd4;
        `IDX_HAUX: haux_q <= wd4;
        `IDX_LAUX: laux_q <= wd4;
        `IDX_CCFLAGS: carry_flag <= writedata[0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // RAM: never reset, so it survives a reset out of stop
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    // a push lays pc low at sp and the flags digit at sp - 3
    if (push) begin
      mem[stk(sp_q, 3'd0, 1'b0)] <= pc_q[3:0];
      mem[stk(sp_q, 3'd1, 1'b0)] <= pc_q[7:4];
      mem[stk(sp_q, 3'd2, 1'b0)] <= pc_q[11:8];
      mem[stk(sp_q, 3'd3, 1'b0)] <=
        {condition_flag, carry_flag, pc_q[13:12]};
    end else if (ram_wr && !sfr) begin
      mem[phys(address[9:0], bank_q)] <= wd4;
    end
  end

  // ----------------------------------------------------------------
  // control registers with reset
  // ----------------------------------------------------------------
  always @(posedge core_clk or posedge rst_sync_q) begin
    if (rst_sync_q) begin
      pc_q                 <= `RST_PC;
      sp_q                 <= `RST_SP;
      condition_flag       <= 1'b1;
      bank_q               <= `RST_BANK;
      global_irq_enable    <= 1'b0;
      irq_req_q            <= 6'h00;
      irq_mask_bit         <= `RST_IRQ_MASK;
      port_out_q           <= `RST_PORT_OUT;
      port_dir_q           <= `RST_PORT_DIR;
      low_speed_flag       <= 1'b0;
      watchdog_flag        <= 1'b0;
      direct_transfer_flag <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        periph_q[i] <= `RST_PERIPH;
      end
      ind_addr_q           <= 10'h000;
      port_line_q          <= 16'h0000;
      readdata             <= 32'h00000000;
      waitrequest          <= 1'b1;
    end else begin
      ind_addr_q  <= ind;
      port_line_q <= 16'h0001 << lidx_q;
      // one wait state: low for the cycle after the taking edge
      waitrequest <= ~req;
      if (op_go) begin
        case (op)
          `OP_ADD:     condition_flag <= sum[4];
          `OP_COMPARE: condition_flag <= acc_q != ind_m;
          `OP_BIT_TEST:
            condition_flag <= ind_m[writedata[5:4]];
          `OP_BRANCH: begin
            if (condition_flag) begin
              pc_q <= target;
            end else begin
              pc_q <= pc_q + 14'h0001;
            end
            condition_flag <= 1'b1;
          end
          `OP_CALL: begin
            if (condition_flag) begin
              pc_q <= target;
              sp_q <= sp_q - `STACK_STEP;
            end else begin
              pc_q <= pc_q + 14'h0001;
            end
            condition_flag <= 1'b1;
          end
          `OP_INT_ENTRY: begin
            pc_q              <= target;
            sp_q              <= sp_q - `STACK_STEP;
            global_irq_enable <= 1'b0;
          end
          `OP_RET: begin
            pc_q <= ret_pc;
            sp_q <= sp_q + `STACK_STEP;
          end
          `OP_RET_INT: begin
            pc_q              <= ret_pc;
            sp_q              <= sp_q + `STACK_STEP;
            condition_flag    <= pd3[3];
            global_irq_enable <= 1'b1;
          end
          `OP_PC_STEP: pc_q <= pc_q + 14'h0001;
          default: begin
          end
        endcase
      // plain register writes; an op write never lands as data
      end else if (wr) begin
        case (address)
          `IDX_BANK_SEL: bank_q <= wd4;
          // request flags can only be cleared by software
          `IDX_IRQ0: begin
            global_irq_enable <= writedata[0];
            if (!writedata[1]) begin
              sp_q <= `RST_SP;
            end
            irq_req_q[0]    <= irq_req_q[0] & writedata[2];
            irq_mask_bit[0] <= writedata[3];
          end
          `IDX_IRQ1: begin
            irq_req_q[1]    <= irq_req_q[1] & writedata[0];
            irq_mask_bit[1] <= writedata[1];
            irq_req_q[2]    <= irq_req_q[2] & writedata[2];
            irq_mask_bit[2] <= writedata[3];
          end
          `IDX_IRQ2: begin
            irq_req_q[3]    <= irq_req_q[3] & writedata[0];
            irq_mask_bit[3] <= writedata[1];
            irq_req_q[4]    <= irq_req_q[4] & writedata[2];
            irq_mask_bit[4] <= writedata[3];
          end
          `IDX_IRQ3: begin
            irq_req_q[5]    <= irq_req_q[5] & writedata[0];
            irq_mask_bit[5] <= writedata[1];
          end
          // watchdog flag only sets, direct-transfer flag only clears
          `IDX_FLAGS: begin
            low_speed_flag       <= writedata[0];
            watchdog_flag        <= watchdog_flag | writedata[1];
            direct_transfer_flag <= direct_transfer_flag &
                                    writedata[3];
          end
          `IDX_CCFLAGS: condition_flag <= writedata[1];
          `IDX_PC:       pc_q       <= writedata[13:0];
          `IDX_SP:       sp_q       <= writedata[9:0];
          `IDX_PORT_OUT: port_out_q <= wd4;
          `IDX_PORT_DIR: port_dir_q <= wd4;
          default: begin
            if (address >= `IDX_PERIPH0 &&
                address <= `IDX_PERIPH_END) begin
              periph_q[address[3:0]] <= writedata[7:0];
            end
          end
        endcase
      end
      // read data load at the taking edge and stand until the next read
      if (req && read) begin
        readdata <= 32'h00000000;
        if (address <= `IDX_RAM_LAST) begin
          case (address)
            `IDX_BANK_SEL: readdata[3:0] <= bank_q;
            `IDX_IRQ0: readdata[3:0] <= {irq_mask_bit[0],
                         irq_req_q[0], 1'b1, global_irq_enable};
            `IDX_IRQ1: readdata[3:0] <= {irq_mask_bit[2],
                         irq_req_q[2], irq_mask_bit[1], irq_req_q[1]};
            `IDX_IRQ2: readdata[3:0] <= {irq_mask_bit[4],
                         irq_req_q[4], irq_mask_bit[3], irq_req_q[3]};
            `IDX_IRQ3: readdata[3:0] <= {2'b00,
                         irq_mask_bit[5], irq_req_q[5]};
            `IDX_FLAGS: readdata[3:0] <= {direct_transfer_flag,
                          1'b0, watchdog_flag, low_speed_flag};
            default:
              readdata[3:0] <= mem[phys(address[9:0], bank_q)];
          endcase
        end else begin
          case (address)
            `IDX_ACC:      readdata[3:0]  <= acc_q;
            `IDX_BREG:     readdata[3:0]  <= breg_q;
            `IDX_PAGE:     readdata[1:0]  <= page_q;
            `IDX_HIDX:     readdata[3:0]  <= hidx_q;
            `IDX_LIDX:     readdata[3:0]  <= lidx_q;
            `IDX_HAUX:     readdata[3:0]  <= haux_q;
            `IDX_LAUX:     readdata[3:0]  <= laux_q;
            `IDX_CCFLAGS:
              readdata[1:0] <= {condition_flag, carry_flag};
            `IDX_PC:       readdata[13:0] <= pc_q;
            `IDX_SP:       readdata[9:0]  <= sp_q;
            `IDX_PORT_OUT: readdata[3:0]  <= port_out_q;
            `IDX_PORT_DIR: readdata[3:0]  <= port_dir_q;
            default: begin
              if (address >= `IDX_PERIPH0 &&
                  address <= `IDX_PERIPH_END) begin
                readdata[7:0] <= periph_q[address[3:0]];
              end
            end
          endcase
        end
      end
    end
  end

endmodule // cpu_regs

//--- shared/cpu_regs_map.vh
`ifndef CPU_REGS_MAP_VH
`define CPU_REGS_MAP_VH
// word indices on the bus (byte address = 4 * index)
`define IDX_RAM_LAST   11'h3FF
`define IDX_IRQ0       11'h000
`define IDX_IRQ1       11'h001
`define IDX_IRQ2       11'h002
`define IDX_IRQ3       11'h003
`define IDX_FLAGS      11'h020
`define IDX_BANK_SEL   11'h03F
`define IDX_ACC        11'h400
`define IDX_BREG       11'h401
`define IDX_PAGE       11'h402
`define IDX_HIDX       11'h403
`define IDX_LIDX       11'h404
`define IDX_HAUX       11'h405
`define IDX_LAUX       11'h406
`define IDX_CCFLAGS    11'h407
`define IDX_PC         11'h408
`define IDX_SP         11'h409
`define IDX_OP         11'h40A
`define IDX_PORT_OUT   11'h40B
`define IDX_PORT_DIR   11'h40C
`define IDX_PERIPH0    11'h410
`define IDX_PERIPH_END 11'h41F
// banked range and bank 1 placement
`define BANK_LO        10'h100
`define BANK_HI        10'h2CF
`define BANK1_BASE     11'h400
`define RAM_DEPTH      1488
// reset values
`define RST_PC         14'h0000
`define RST_SP         10'h3FF
`define RST_BANK       4'h0
`define RST_PORT_OUT   4'hF
`define RST_PORT_DIR   4'h0
`define RST_PERIPH     8'h00
`define RST_IRQ_MASK   6'h3F
`define STACK_STEP     10'h004
// operation codes written to the op register
`define OP_ADD         4'h1
`define OP_SET_CARRY   4'h2
`define OP_CLR_CARRY   4'h3
`define OP_ROT_LEFT    4'h4
`define OP_ROT_RIGHT   4'h5
`define OP_BRANCH      4'h6
`define OP_CALL        4'h7
`define OP_RET         4'h8
`define OP_RET_INT     4'h9
`define OP_INT_ENTRY   4'hA
`define OP_XCHG_HIGH   4'hB
`define OP_XCHG_LOW    4'hC
`define OP_COMPARE     4'hD
`define OP_BIT_TEST    4'hE
`define OP_PC_STEP     4'hF
`endif

//--- verif/cpu_regs_checker.sv
`timescale 1ns/10ps
`include "cpu_regs_map.vh"

module cpu_regs_checker (
  // clock and reset
  input wire        core_clk,
  input wire        rst,
  // bus
  input wire [10:0] address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // core state
  input wire [13:0] pc_q,
  input wire [9:0]  sp_q,
  input wire [9:0]  ind_addr_q,
  input wire [15:0] port_line_q,
  input wire [3:0]  port_out_q,
  input wire [3:0]  port_dir_q
);
  // ------------------------------------------------------------
  // bus and core state relations
  // ------------------------------------------------------------
  // the core stays in reset two edges after the pin lets go
  logic [1:0] rst_tail_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rst_tail_q <= 2'h3;
    end else if (rst_tail_q != 2'h0) begin
      rst_tail_q <= rst_tail_q - 2'h1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst || rst_tail_q != 2'h0);
  wire take  = (read || write) && waitrequest;
  wire wtake = write && waitrequest;
  wire op_w  = wtake && address == `IDX_OP;

  a_wait_answer: assert property (take |=> !waitrequest)
    else $error("request not answered after one wait state");
  a_wait_single: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_cause: assert property (!waitrequest |-> $past(take))
    else $error("waitrequest low without a taken request");
  a_pc_step: assert property (
    op_w && writedata[3:0] == `OP_PC_STEP |=> pc_q == $past(pc_q) + 14'h1)
    else $error("pc step did not add one");
  a_pc_cause: assert property ($changed(pc_q) |-> $past(wtake))
    else $error("pc changed without a write");
  a_sp_step: assert property ($changed(sp_q) |->
    sp_q == $past(sp_q) - 10'h004 || sp_q == $past(sp_q) + 10'h004 ||
    sp_q == 10'h3FF)
    else $error("stack pointer moved by other than four");
  a_sp_reload: assert property (
    wtake && address == `IDX_IRQ0 && !writedata[1] |=> sp_q == 10'h3FF)
    else $error("stack bit clear did not reload sp");
  a_line_onehot: assert property (
    port_line_q != 16'h0000 |-> port_line_q == 16'h0001 << ind_addr_q[3:0])
    else $error("port line does not follow low index");
  a_out_cause: assert property ($changed(port_out_q) |->
    $past(wtake && address == `IDX_PORT_OUT))
    else $error("port output changed without its write");
  a_dir_cause: assert property ($changed(port_dir_q) |->
    $past(wtake && address == `IDX_PORT_DIR))
    else $error("port direction changed without its write");
endmodule // cpu_regs_checker

bind cpu_regs cpu_regs_checker i_chk (
  .core_clk(core_clk), .rst(rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .pc_q(pc_q), .sp_q(sp_q),
  .ind_addr_q(ind_addr_q), .port_line_q(port_line_q),
  .port_out_q(port_out_q), .port_dir_q(port_dir_q));

//--- verif/tb.sv
`timescale 1ns/10ps
`include "cpu_regs_map.vh"

module tb;
  logic        core_clk  = 1'b0;
  logic        rst       = 1'b1;
  logic [10:0] address   = 11'h000;
  logic        read      = 1'b0;
  logic        write     = 1'b0;
  logic [31:0] writedata = 32'h0;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire  [13:0] pc_q;
  wire  [9:0]  sp_q;
  wire  [9:0]  ind_addr_q;
  wire  [15:0] port_line_q;
  wire  [3:0]  port_out_q;
  wire  [3:0]  port_dir_q;
  int          n_fail    = 0;
  int          cmp_count = 0;
  logic [31:0] q;
  logic [13:0] p;

  always #12.5 core_clk = ~core_clk;

  cpu_regs i_dut (
    .core_clk(core_clk), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .pc_q(pc_q), .sp_q(sp_q),
    .ind_addr_q(ind_addr_q), .port_line_q(port_line_q),
    .port_out_q(port_out_q), .port_dir_q(port_dir_q));

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic bus(input logic rw, input logic [10:0] a,
                     input logic [31:0] d);
    begin
      @(posedge core_clk);
      address <= a;
      writedata <= d;
      read <= rw;
      write <= ~rw;
      do begin
        @(posedge core_clk);
      end while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      cmp_count++;
      if (g !== e) begin
        n_fail++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic rc(input logic [10:0] a, input logic [31:0] e);
    begin
      bus(1'b1, a, 32'h0);
      chk(q, e);
    end
  endtask
  task automatic print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rst_vals;
    int i;
    begin
      chk({18'h0, pc_q}, 32'h0);
      chk({22'h0, sp_q}, 32'h3FF);
      chk({28'h0, port_out_q}, 32'hF);
      chk({28'h0, port_dir_q}, 32'h0);
      rc(`IDX_BANK_SEL, 32'h0);
      rc(`IDX_IRQ0, 32'hA);
      rc(`IDX_IRQ1, 32'hA);
      rc(`IDX_IRQ2, 32'hA);
      rc(`IDX_IRQ3, 32'h2);
      rc(`IDX_FLAGS, 32'h0);
      bus(1'b1, `IDX_CCFLAGS, 32'h0);
      chk({31'h0, q[1]}, 32'h1);
      for (i = 0; i < 16; i++) begin
        rc(11'(`IDX_PERIPH0 + i), 32'h0);
      end
      $display("reset values done");
    end
  endtask
  task automatic t_bank;
    begin
      wr(`IDX_BANK_SEL, 32'h0);
      wr(11'h150, 32'h5);
      wr(`IDX_BANK_SEL, 32'h1);
      wr(11'h150, 32'hA);
      wr(11'h0C0, 32'h3);
      wr(11'h310, 32'h6);
      wr(11'h7FF, 32'hF);
      rc(`IDX_BANK_SEL, 32'h1);
      rc(11'h150, 32'hA);
      wr(`IDX_BANK_SEL, 32'h0);
      rc(11'h150, 32'h5);
      rc(11'h0C0, 32'h3);
      rc(11'h310, 32'h6);
      rc(11'h7FF, 32'h0);
      $display("bank select done");
    end
  endtask
  task automatic t_index;
    begin
      wr(`IDX_PAGE, 32'h2);
      wr(`IDX_HIDX, 32'h5);
      wr(`IDX_LIDX, 32'h9);
      @(posedge core_clk);
      chk({22'h0, ind_addr_q}, 32'h259);
      chk({16'h0, port_line_q}, 32'h200);
      wr(`IDX_HAUX, 32'hC);
      wr(`IDX_LAUX, 32'h6);
      wr(`IDX_OP, {28'h0, `OP_XCHG_HIGH});
      wr(`IDX_OP, {28'h0, `OP_XCHG_LOW});
      rc(`IDX_HIDX, 32'hC);
      rc(`IDX_HAUX, 32'h5);
      rc(`IDX_LIDX, 32'h6);
      rc(`IDX_LAUX, 32'h9);
      chk({22'h0, ind_addr_q}, 32'h2C6);
      $display("index registers done");
    end
  endtask
  task automatic t_alu;
    begin
      wr(`IDX_PAGE, 32'h0);
      wr(`IDX_HIDX, 32'hC);
      wr(`IDX_LIDX, 32'h5);
      wr(11'h0C5, 32'h2);
      wr(`IDX_ACC, 32'hF);
      wr(`IDX_CCFLAGS, 32'h0);
      wr(`IDX_OP, {28'h0, `OP_ADD});
      rc(`IDX_ACC, 32'h1);
      rc(`IDX_CCFLAGS, 32'h3);
      wr(`IDX_OP, {28'h0, `OP_CLR_CARRY});
      rc(`IDX_CCFLAGS, 32'h2);
      wr(`IDX_OP, {28'h0, `OP_SET_CARRY});
      rc(`IDX_CCFLAGS, 32'h3);
      wr(`IDX_OP, {28'h0, `OP_CLR_CARRY});
      wr(`IDX_ACC, 32'h9);
      wr(`IDX_OP, {28'h0, `OP_ROT_LEFT});
      rc(`IDX_ACC, 32'h2);
      rc(`IDX_CCFLAGS, 32'h3);
      wr(`IDX_OP, {28'h0, `OP_ROT_RIGHT});
      rc(`IDX_ACC, 32'h9);
      wr(`IDX_ACC, 32'h2);
      wr(`IDX_OP, {28'h0, `OP_COMPARE});
      wr(`IDX_OP, {28'h0, `OP_PC_STEP});
      rc(`IDX_CCFLAGS, 32'h0);
      p = pc_q;
      wr(`IDX_OP, {14'h0, 14'h0123, `OP_BRANCH});
      chk({18'h0, pc_q}, {18'h0, p + 14'h1});
      rc(`IDX_CCFLAGS, 32'h2);
      wr(`IDX_OP, {14'h0, 14'h0123, `OP_BRANCH});
      chk({18'h0, pc_q}, 32'h123);
      wr(`IDX_OP, {28'h0, `OP_BIT_TEST});
      rc(`IDX_CCFLAGS, 32'h0);
      wr(`IDX_PC, 32'h3FFF);
      wr(`IDX_OP, {28'h0, `OP_PC_STEP});
      chk({18'h0, pc_q}, 32'h0);
      $display("alu flags done");
    end
  endtask
  task automatic t_stack;
    begin
      wr(`IDX_PC, 32'h1234);
      wr(`IDX_CCFLAGS, 32'h3);
      wr(`IDX_OP, {14'h0, 14'h0040, `OP_INT_ENTRY});
      chk({18'h0, pc_q}, 32'h40);
      chk({22'h0, sp_q}, 32'h3FB);
      rc(11'h3FF, 32'h4);
      rc(11'h3FC, 32'hD);
      rc(`IDX_IRQ0, 32'hA);
      wr(`IDX_CCFLAGS, 32'h0);
      wr(`IDX_OP, {14'h0, 14'h0200, `OP_CALL});
      chk({22'h0, sp_q}, 32'h3FB);
      rc(`IDX_CCFLAGS, 32'h2);
      wr(`IDX_OP, {14'h0, 14'h0200, `OP_CALL});
      chk({22'h0, sp_q}, 32'h3F7);
      chk({18'h0, pc_q}, 32'h200);
      wr(`IDX_CCFLAGS, 32'h0);
      wr(`IDX_OP, {28'h0, `OP_RET});
      chk({22'h0, sp_q}, 32'h3FB);
      chk({18'h0, pc_q}, 32'h41);
      rc(`IDX_CCFLAGS, 32'h0);
      wr(`IDX_OP, {28'h0, `OP_RET_INT});
      chk({22'h0, sp_q}, 32'h3FF);
      chk({18'h0, pc_q}, 32'h1234);
      rc(`IDX_CCFLAGS, 32'h3);
      rc(`IDX_IRQ0, 32'hB);
      wr(`IDX_OP, {14'h0, 14'h0040, `OP_INT_ENTRY});
      wr(`IDX_IRQ0, 32'h8);
      chk({22'h0, sp_q}, 32'h3FF);
      rc(`IDX_IRQ0, 32'hA);
      $display("stack done");
    end
  endtask
  task automatic t_mid_reset;
    begin
      wr(`IDX_PORT_OUT, 32'h5);
      wr(`IDX_PORT_DIR, 32'hF);
      chk({28'h0, port_out_q, port_dir_q}, 32'h5F);
      wr(`IDX_BANK_SEL, 32'h1);
      wr(11'h0C0, 32'h7);
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      t_rst_vals;
      rc(11'h0C0, 32'h7);
      $display("mid-run reset done");
    end
  endtask

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    t_rst_vals;
    t_bank;
    t_index;
    t_alu;
    t_stack;
    t_mid_reset;
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    print_verdict;
  end
endmodule // tb
